// ### tioc_pkg.sv
// tioc_pkg: constants and types shared by the timer i/o control block
// assumes a 16-bit register port and 16-bit timer counters
package tioc_pkg;

	// register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 16;
	localparam int EVT_W  = 4;

	// register indexes on the plain register port
	localparam logic [3:0] ADDR_CD_SEL  = 4'h0; // channel0_cd_io_select
	localparam logic [3:0] ADDR_CH1_SEL = 4'h1; // channel1_io_select
	localparam logic [3:0] ADDR_REG_C   = 4'h2; // ch0_general_reg_c
	localparam logic [3:0] ADDR_REG_D   = 4'h3; // ch0_general_reg_d
	localparam logic [3:0] ADDR_REG_B1  = 4'h4; // ch1_general_reg_b
	localparam logic [3:0] ADDR_CTRL    = 4'h5; // ch0_mode_register subset
	localparam logic [3:0] ADDR_STATUS  = 4'h6; // event status, read only
	localparam logic [3:0] ADDR_CLEAR   = 4'h7; // event clear, write only
	localparam logic [3:0] ADDR_ENABLE  = 4'h8; // event interrupt enable

	// values after reset
	localparam logic [7:0]  RST_SEL = 8'h00;
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [3:0]  RST_EVT = 4'h0;

	// field positions inside the select registers
	localparam int CD_SEL_W     = 7;  // bit 7 is reserved, reads zero
	localparam int FLD_C_LSB    = 0;  // reg_c_function_field, 4 bits
	localparam int FLD_D_LSB    = 4;  // reg_d_function_field, 3 bits
	localparam int FLD_B1_LSB   = 4;  // reg_b_function_field of channel 1, 4 bits
	localparam int FLD_CAP_BIT  = 3;  // 1 selects capture, 0 selects compare
	localparam int FLD_INIT_BIT = 2;  // initial pin level in compare mode
	localparam int CTRL_BFA_BIT = 0;  // buffer_enable_a

	// event bit positions in status, clear and enable
	localparam int EVT_CAP_C   = 0;
	localparam int EVT_MATCH_C = 1;
	localparam int EVT_MATCH_D = 2;
	localparam int EVT_MATCH_B = 3;

	// number of compare pin units
	localparam int N_CMP   = 3;
	localparam int CMP_C   = 0;
	localparam int CMP_D   = 1;
	localparam int CMP_B1  = 2;

	// compare-match action held in the two low code bits
	typedef enum logic [1:0] {
		TIOC_ACT_OFF    = 2'b00,
		TIOC_ACT_LOW    = 2'b01,
		TIOC_ACT_HIGH   = 2'b10,
		TIOC_ACT_TOGGLE = 2'b11
	} tioc_action_type;

	// capture source codes for register c (upper bits only, x bits dropped)
	localparam logic [3:0] CAP_RISE = 4'h8;
	localparam logic [3:0] CAP_FALL = 4'h9;
	localparam logic [2:0] CAP_BOTH = 3'h5; // code[3:1] == 101
	localparam logic [1:0] CAP_CH1  = 2'h3; // code[3:2] == 11

endpackage

// ### tioc_compare_pin.sv
// tioc_compare_pin: drives one compare output pin from a 3-bit code
// assumes load and match are one-cycle pulses on clock_i
`timescale 1ns/1ps
module tioc_compare_pin (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] code_i,
	input  wire logic       active_i,
	input  wire logic       load_i,
	input  wire logic       match_i,
	output logic            pin_o,
	output logic            pin_oe_o
);

	typedef struct packed {
		logic level;
		logic oe;
	} tioc_pin_state_type;

	tioc_pin_state_type state_q;
	tioc_pin_state_type state_d;
	tioc_pkg::tioc_action_type action;

	assign action = tioc_pkg::tioc_action_type'(code_i[1:0]);

	// next pin level; a new code restarts the pin at its initial level
	always_comb
	begin
		state_d = state_q;
		// [R9] disabled code, initial level
		state_d.oe = active_i && (action != tioc_pkg::TIOC_ACT_OFF);
		if (load_i)
		begin
			state_d.level = code_i[tioc_pkg::FLD_INIT_BIT];
		end
		else if (match_i && active_i)
		begin
			unique case (action)
				tioc_pkg::TIOC_ACT_OFF:    state_d.level = state_q.level;
				// [R1] low on match
				tioc_pkg::TIOC_ACT_LOW:    state_d.level = 1'b0;
				// [R2] high on match
				tioc_pkg::TIOC_ACT_HIGH:   state_d.level = 1'b1;
				// [R3] toggle on match
				tioc_pkg::TIOC_ACT_TOGGLE: state_d.level = ~state_q.level;
			endcase
		end
	end

	// state register
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign pin_o    = state_q.level;
	assign pin_oe_o = state_q.oe;

endmodule

// ### tioc_io_control.sv
// tioc_io_control: i/o function selection for general registers c and d of
// channel 0 and register b of channel 1, with compare pins and capture on c.
// assumes counters and the channel 1 count pulse come from logic on clock_i;
// the capture pin comes from outside and is synchronised here.
//
// register index map on the plain port:
//   0 channel0_cd_io_select, 1 channel1_io_select, 2 ch0_general_reg_c,
//   3 ch0_general_reg_d, 4 ch1_general_reg_b, 5 control (buffer_enable_a),
//   6 event status (read only), 7 event clear (write only), 8 event enable
// event bits: 0 capture into c, 1 match c, 2 match d, 3 match channel 1 b
// timing: a select write reaches the pins one edge later; a compare match
// moves its pin one edge after equality begins; a pin edge reaches
// register c three edges after the pin moves (two sync stages, one detect)
// limitation: channel 1 register b only compares; its capture codes merely
// turn its pin off
//
// How it works
// [R1] action 01: pin goes low on match
// [R2] action 10: pin goes high on match
// [R3] action 11: pin toggles on every match
// [R4] code 1000: capture c on rising pin edge
// [R5] code 1001: capture c on falling pin edge
// [R6] code 101x: capture c on both edges
// [R7] buffer enable a: register c neither captures nor compares
// [R8] code 11xx: capture c on channel 1 count
// [R9] x000 disables pin; bit 2 sets initial level
// [R10] select registers reset to zero
`timescale 1ns/1ps
module tioc_io_control (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// register port
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	// timer counters and channel 1 count pulse
	input  wire logic [15:0] ch0_counter_i,
	input  wire logic [15:0] ch1_counter_i,
	input  wire logic        ch1_count_i,
	// pins
	input  wire logic        ch0_pin_c_i,
	output logic             ch0_pin_c_o,
	output logic             ch0_pin_c_oe_o,
	output logic             ch0_pin_d_o,
	output logic             ch0_pin_d_oe_o,
	output logic             ch1_pin_b_o,
	output logic             ch1_pin_b_oe_o,
	// interrupt
	output logic             irq_o
);

	typedef struct packed {
		logic [6:0]  cd_sel;     // channel0_cd_io_select, bit 7 not stored
		logic [7:0]  ch1_sel;    // channel1_io_select
		logic [15:0] reg_c;      // ch0_general_reg_c
		logic [15:0] reg_d;      // ch0_general_reg_d
		logic [15:0] reg_b1;     // ch1_general_reg_b
		logic        bfa;        // buffer_enable_a
		logic [3:0]  status;
		logic [3:0]  enable;
		logic [15:0] rdata;
		logic        pin_s1;     // synchroniser first stage
		logic        pin_s2;     // synchroniser second stage
		logic        pin_prev;   // for edge detection
		logic [2:0]  eq_prev;    // compare equality, last cycle
	} tioc_state_type;

	tioc_state_type state_q;
	tioc_state_type state_d;

	// stored register c code, used for capture source selection
	logic [3:0] code_c;
	logic       c_is_capture;
	logic       b1_is_capture;

	assign code_c = state_q.cd_sel[tioc_pkg::FLD_C_LSB +: 4];

	// write and read decode
	logic wr_cd;
	logic wr_ch1;
	logic wr_c;
	logic wr_d;
	logic wr_b1;
	logic wr_ctrl;
	logic wr_clear;
	logic wr_enable;

	assign wr_cd     = wr_i && (addr_i == tioc_pkg::ADDR_CD_SEL);
	assign wr_ch1    = wr_i && (addr_i == tioc_pkg::ADDR_CH1_SEL);
	assign wr_c      = wr_i && (addr_i == tioc_pkg::ADDR_REG_C);
	assign wr_d      = wr_i && (addr_i == tioc_pkg::ADDR_REG_D);
	assign wr_b1     = wr_i && (addr_i == tioc_pkg::ADDR_REG_B1);
	assign wr_ctrl   = wr_i && (addr_i == tioc_pkg::ADDR_CTRL);
	assign wr_clear  = wr_i && (addr_i == tioc_pkg::ADDR_CLEAR);
	assign wr_enable = wr_i && (addr_i == tioc_pkg::ADDR_ENABLE);

	// compare equalities; a match acts once when equality begins, so a
	// counter that dwells on the value for many cycles toggles only once
	logic [2:0] eq_now;
	logic [2:0] match;
	logic [2:0] cmp_active;
	logic [2:0] cmp_load;
	logic [8:0] cmp_code;

	assign eq_now[tioc_pkg::CMP_C]  = (ch0_counter_i == state_q.reg_c);
	assign eq_now[tioc_pkg::CMP_D]  = (ch0_counter_i == state_q.reg_d);
	assign eq_now[tioc_pkg::CMP_B1] = (ch1_counter_i == state_q.reg_b1);
	assign match = eq_now & ~state_q.eq_prev;

	// next select values: a unit loads and enables from the code being
	// written, otherwise the pin would take the old code at the write edge
	// and the new one only a cycle later
	logic [6:0] cd_sel_next;
	logic [7:0] ch1_sel_next;
	logic       bfa_next;
	logic [3:0] code_c_next;
	logic [2:0] code_d_next;
	logic [3:0] code_b1_next;

	assign cd_sel_next   = wr_cd ? wdata_i[tioc_pkg::CD_SEL_W-1:0] : state_q.cd_sel;
	assign ch1_sel_next  = wr_ch1 ? wdata_i[7:0] : state_q.ch1_sel;
	assign bfa_next      = wr_ctrl ? wdata_i[tioc_pkg::CTRL_BFA_BIT] : state_q.bfa;
	assign code_c_next   = cd_sel_next[tioc_pkg::FLD_C_LSB +: 4];
	assign code_d_next   = cd_sel_next[tioc_pkg::FLD_D_LSB +: 3];
	assign code_b1_next  = ch1_sel_next[tioc_pkg::FLD_B1_LSB +: 4];
	assign c_is_capture  = code_c_next[tioc_pkg::FLD_CAP_BIT];
	assign b1_is_capture = code_b1_next[tioc_pkg::FLD_CAP_BIT];

	// compare unit setup; register c drops out while it serves as buffer
	// [R7] buffer blocks compare
	assign cmp_active[tioc_pkg::CMP_C]  = !c_is_capture && !bfa_next;
	assign cmp_active[tioc_pkg::CMP_D]  = 1'b1;
	assign cmp_active[tioc_pkg::CMP_B1] = !b1_is_capture;
	assign cmp_load[tioc_pkg::CMP_C]    = wr_cd;
	assign cmp_load[tioc_pkg::CMP_D]    = wr_cd;
	assign cmp_load[tioc_pkg::CMP_B1]   = wr_ch1;
	assign cmp_code[3*tioc_pkg::CMP_C +: 3]  = code_c_next[2:0];
	assign cmp_code[3*tioc_pkg::CMP_D +: 3]  = code_d_next;
	assign cmp_code[3*tioc_pkg::CMP_B1 +: 3] = code_b1_next[2:0];

	logic [2:0] pin_level;
	logic [2:0] pin_oe;

	// one compare pin unit per general register that can drive a pin
	genvar gi;
	generate
		for (gi = 0; gi < tioc_pkg::N_CMP; gi++)
		begin : g_cmp
			tioc_compare_pin u_pin (
				.clock_i  (clock_i),
				.rst_i    (rst_i),
				.code_i   (cmp_code[3*gi +: 3]),
				.active_i (cmp_active[gi]),
				.load_i   (cmp_load[gi]),
				.match_i  (match[gi]),
				.pin_o    (pin_level[gi]),
				.pin_oe_o (pin_oe[gi])
			);
		end
	endgenerate

	assign ch0_pin_c_o    = pin_level[tioc_pkg::CMP_C];
	assign ch0_pin_c_oe_o = pin_oe[tioc_pkg::CMP_C];
	assign ch0_pin_d_o    = pin_level[tioc_pkg::CMP_D];
	assign ch0_pin_d_oe_o = pin_oe[tioc_pkg::CMP_D];
	assign ch1_pin_b_o    = pin_level[tioc_pkg::CMP_B1];
	assign ch1_pin_b_oe_o = pin_oe[tioc_pkg::CMP_B1];

	// capture pin edges, taken after the second synchroniser stage only
	logic pin_rise;
	logic pin_fall;
	logic cap_hit;

	assign pin_rise = state_q.pin_s2 && !state_q.pin_prev;
	assign pin_fall = !state_q.pin_s2 && state_q.pin_prev;

	// capture source select for register c
	always_comb
	begin
		cap_hit = 1'b0;
		if (code_c[3:2] == tioc_pkg::CAP_CH1)
			// [R8] channel 1 count
			cap_hit = ch1_count_i;
		else if (code_c[3:1] == tioc_pkg::CAP_BOTH)
			// [R6] both edges
			cap_hit = pin_rise || pin_fall;
		else if (code_c == tioc_pkg::CAP_RISE)
			// [R4] rising edge
			cap_hit = pin_rise;
		else if (code_c == tioc_pkg::CAP_FALL)
			// [R5] falling edge
			cap_hit = pin_fall;
	end

	logic cap_c;
	// [R7] buffer blocks capture
	assign cap_c = cap_hit && !state_q.bfa;

	// events seen this cycle
	logic [3:0] evt;
	always_comb
	begin
		evt = '0;
		evt[tioc_pkg::EVT_CAP_C]   = cap_c;
		evt[tioc_pkg::EVT_MATCH_C] = match[tioc_pkg::CMP_C] && cmp_active[tioc_pkg::CMP_C];
		evt[tioc_pkg::EVT_MATCH_D] = match[tioc_pkg::CMP_D];
		evt[tioc_pkg::EVT_MATCH_B] = match[tioc_pkg::CMP_B1] && cmp_active[tioc_pkg::CMP_B1];
	end

	// read multiplexer; unmapped and write-only indexes read zero
	logic [15:0] rd_mux;
	always_comb
	begin
		rd_mux = '0;
		unique case (addr_i)
			tioc_pkg::ADDR_CD_SEL:  rd_mux = {9'h000, state_q.cd_sel};
			tioc_pkg::ADDR_CH1_SEL: rd_mux = {8'h00, state_q.ch1_sel};
			tioc_pkg::ADDR_REG_C:   rd_mux = state_q.reg_c;
			tioc_pkg::ADDR_REG_D:   rd_mux = state_q.reg_d;
			tioc_pkg::ADDR_REG_B1:  rd_mux = state_q.reg_b1;
			tioc_pkg::ADDR_CTRL:    rd_mux = {15'h0000, state_q.bfa};
			tioc_pkg::ADDR_STATUS:  rd_mux = {12'h000, state_q.status};
			tioc_pkg::ADDR_ENABLE:  rd_mux = {12'h000, state_q.enable};
			default:                rd_mux = '0;
		endcase
	end

	// next state of the whole block
	always_comb
	begin
		state_d = state_q;

		// pin synchroniser and edge history
		state_d.pin_s1   = ch0_pin_c_i;
		state_d.pin_s2   = state_q.pin_s1;
		state_d.pin_prev = state_q.pin_s2;
		state_d.eq_prev  = eq_now;

		// register writes
		if (wr_cd)
			state_d.cd_sel = wdata_i[tioc_pkg::CD_SEL_W-1:0];
		if (wr_ch1)
			state_d.ch1_sel = wdata_i[7:0];
		if (wr_d)
			state_d.reg_d = wdata_i;
		if (wr_b1)
			state_d.reg_b1 = wdata_i;
		if (wr_ctrl)
			state_d.bfa = wdata_i[tioc_pkg::CTRL_BFA_BIT];
		if (wr_enable)
			state_d.enable = wdata_i[3:0];

		// a capture in the same cycle as a software write keeps the
		// counter value, since the timed event cannot be repeated
		if (cap_c)
			state_d.reg_c = ch0_counter_i;
		else if (wr_c)
			state_d.reg_c = wdata_i;

		// sticky status: the set wins over a clear in the same cycle
		if (wr_clear)
			state_d.status = state_q.status & ~wdata_i[3:0];
		state_d.status = state_d.status | evt;

		// read data stand in the cycle after the strobe only
		state_d.rdata = rd_i ? rd_mux : '0;
	end

	// state register
	// [R10] zero after reset
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q         <= '0;
			state_q.cd_sel  <= tioc_pkg::RST_SEL[6:0];
			state_q.ch1_sel <= tioc_pkg::RST_SEL;
			state_q.reg_c   <= tioc_pkg::RST_REG;
			state_q.reg_d   <= tioc_pkg::RST_REG;
			state_q.reg_b1  <= tioc_pkg::RST_REG;
			state_q.status  <= tioc_pkg::RST_EVT;
			state_q.enable  <= tioc_pkg::RST_EVT;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign rdata_o = state_q.rdata;
	assign irq_o   = |(state_q.status & state_q.enable);

endmodule

// ### tioc_io_control_sva.sv
// tioc_io_control_sva: port checker for the timer i/o control block
// assumes one clock_i domain and an asynchronous active-high rst_i
`timescale 1ns/1ps
module tioc_io_control_sva (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        ch0_pin_c_oe_o,
	input wire logic        ch0_pin_d_o,
	input wire logic        ch0_pin_d_oe_o,
	input wire logic        ch1_pin_b_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// writes to the two select registers
	sequence s_cd_wr;
		wr_i && addr_i == tioc_pkg::ADDR_CD_SEL;
	endsequence
	sequence s_b_wr;
		wr_i && addr_i == tioc_pkg::ADDR_CH1_SEL;
	endsequence
	a_rdata_idle: assert property (rdata_o != 16'h0000 |-> $past(rd_i))
		else $error("read data without a read strobe");
	a_reset_quiet: assert property (
		$fell(rst_i) |-> !ch0_pin_c_oe_o && !ch0_pin_d_oe_o && !ch1_pin_b_oe_o && !ch0_pin_d_o)
		else $error("pin driven right after reset");
	a_d_oe_select: assert property (
		s_cd_wr |=> ch0_pin_d_oe_o == ($past(wdata_i[5:4]) != 2'b00))
		else $error("pin d enable does not follow its code");
	a_d_init_level: assert property (
		s_cd_wr ##0 wdata_i[5:4] == 2'b00 |=> ch0_pin_d_o == $past(wdata_i[6]))
		else $error("pin d initial level wrong");
	a_b_oe_select: assert property (
		s_b_wr |=> ch1_pin_b_oe_o == (!$past(wdata_i[7]) && $past(wdata_i[5:4]) != 2'b00))
		else $error("pin b enable does not follow its code");
	a_d_oe_cause: assert property (
		$changed(ch0_pin_d_oe_o) |-> $past(wr_i && addr_i == tioc_pkg::ADDR_CD_SEL))
		else $error("pin d enable moved without a select write");
	a_c_oe_cause: assert property ($rose(ch0_pin_c_oe_o) |-> $past(wr_i))
		else $error("pin c enable rose without a write");
	a_c_capture_off: assert property (s_cd_wr ##0 wdata_i[3] |=> !ch0_pin_c_oe_o)
		else $error("pin c driven in capture mode");
endmodule
bind tioc_io_control tioc_io_control_sva u_sva (
	.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .ch0_pin_c_oe_o(ch0_pin_c_oe_o),
	.ch0_pin_d_o(ch0_pin_d_o), .ch0_pin_d_oe_o(ch0_pin_d_oe_o),
	.ch1_pin_b_oe_o(ch1_pin_b_oe_o)
);

// ### tioc_pin_model.sv
// tioc_pin_model: external source on the capture pin of register c
// assumes nothing of the block's clock: edges land at arbitrary times
`timescale 1ns/1ps
module tioc_pin_model (
	output logic pin_o
);
	// the source idles low until told otherwise
	initial pin_o = 1'b0;
	// move off the clock edge so the synchroniser sees a true async input
	task automatic set_pin(input logic v);
		#7 pin_o = v;
	endtask
endmodule

// ### tioc_io_control_tb_top.sv
// tioc_io_control_tb_top: register-level tests of the timer i/o control block
// assumes the package register map and a 40 MHz clock
`timescale 1ns/1ps
module tioc_io_control_tb_top;
	logic        clock_i, rst_i, wr_i, rd_i, ch1_count_i, ch0_pin_c_i, irq_o;
	logic        ch0_pin_c_o, ch0_pin_c_oe_o, ch0_pin_d_o, ch0_pin_d_oe_o;
	logic        ch1_pin_b_o, ch1_pin_b_oe_o;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i, rdata_o, ch0_counter_i, ch1_counter_i, exp_c;
	int          n_fail, tests_run;
	tioc_io_control u_dut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.ch0_counter_i, .ch1_counter_i, .ch1_count_i, .ch0_pin_c_i, .ch0_pin_c_o,
		.ch0_pin_c_oe_o, .ch0_pin_d_o, .ch0_pin_d_oe_o, .ch1_pin_b_o, .ch1_pin_b_oe_o, .irq_o);
	tioc_pin_model u_pin (.pin_o(ch0_pin_c_i));
	// 25 ns clock
	initial
	begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want)
		begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		// one idle edge, so a following call never drives the strobe twice in one step
		@(posedge clock_i);
	endtask
	// read data stands one cycle only, so look 1 ns after the edge
	task automatic rd(input logic [3:0] a, input logic [15:0] want);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, want);
		@(posedge clock_i);
	endtask
	// one cycle of equality on both counters, pins settle two edges on
	task automatic hit(input logic [15:0] v);
		ch0_counter_i <= v;
		ch1_counter_i <= v;
		@(posedge clock_i);
		ch0_counter_i <= 16'h0000;
		ch1_counter_i <= 16'h0000;
		repeat (2) @(posedge clock_i);
	endtask
	// pin edge; five edges cover the synchroniser and edge detect
	task automatic edge_cap(input logic v, input logic [15:0] c);
		ch0_counter_i <= c;
		u_pin.set_pin(v);
		repeat (5) @(posedge clock_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{wr_i, rd_i, ch1_count_i, addr_i, wdata_i, ch0_counter_i, ch1_counter_i} = '0;
		n_fail = 0;
		tests_run = 0;
		rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		wr(tioc_pkg::ADDR_STATUS, 16'h000F);
		// counters and registers all sit at zero, so equality begins at the
		// first edge after reset and sets match flags; clear them first
		wr(tioc_pkg::ADDR_CLEAR, 16'h000F);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 16'h0000);
		check({13'h0, ch0_pin_c_oe_o, ch0_pin_d_oe_o, ch1_pin_b_oe_o}, 16'h0000);
		wr(tioc_pkg::ADDR_CD_SEL, 16'h00FF);
		rd(tioc_pkg::ADDR_CD_SEL, 16'h007F);
		$display("test reset done");
		wr(tioc_pkg::ADDR_CD_SEL, 16'h0040);
		wr(tioc_pkg::ADDR_REG_D, 16'h0010);
		wr(tioc_pkg::ADDR_REG_B1, 16'h0010);
		wr(tioc_pkg::ADDR_CH1_SEL, 16'h0020);
		wr(tioc_pkg::ADDR_ENABLE, 16'h0004);
		for (int a = 1; a < 4; a++)
		begin
			wr(tioc_pkg::ADDR_CD_SEL, {9'h000, a == 1, a[1:0], 4'h0});
			hit(16'h0010);
			check({15'h0, ch0_pin_d_o}, {15'h0, a != 1});
		end
		hit(16'h0010);
		check({15'h0, ch0_pin_d_o}, 16'h0000);
		check({14'h0, ch1_pin_b_o, ch1_pin_b_oe_o}, 16'h0003);
		check({15'h0, irq_o}, 16'h0001);
		wr(tioc_pkg::ADDR_ENABLE, 16'h0000);
		@(posedge clock_i);
		check({15'h0, irq_o}, 16'h0000);
		wr(tioc_pkg::ADDR_ENABLE, 16'h0004);
		@(posedge clock_i);
		check({15'h0, irq_o}, 16'h0001);
		wr(tioc_pkg::ADDR_CLEAR, 16'h000F);
		@(posedge clock_i);
		check({15'h0, irq_o}, 16'h0000);
		$display("test compare done");
		for (int m = 8; m < 11; m++)
		begin
			wr(tioc_pkg::ADDR_CD_SEL, {12'h000, m[3:0]});
			wr(tioc_pkg::ADDR_REG_C, 16'h0000);
			exp_c = 16'h0000;
			edge_cap(1'b1, {12'h0A0, m[3:0]});
			if (m != 9)
				exp_c = {12'h0A0, m[3:0]};
			rd(tioc_pkg::ADDR_REG_C, exp_c);
			edge_cap(1'b0, {12'h0B0, m[3:0]});
			if (m != 8)
				exp_c = {12'h0B0, m[3:0]};
			rd(tioc_pkg::ADDR_REG_C, exp_c);
		end
		rd(tioc_pkg::ADDR_STATUS, 16'h0001);
		// channel 1 count pulse as capture source
		wr(tioc_pkg::ADDR_CD_SEL, 16'h000C);
		ch0_counter_i <= 16'h0C0C;
		ch1_count_i <= 1'b1;
		@(posedge clock_i);
		ch1_count_i <= 1'b0;
		@(posedge clock_i);
		rd(tioc_pkg::ADDR_REG_C, 16'h0C0C);
		$display("test capture done");
		wr(tioc_pkg::ADDR_CTRL, 16'h0001);
		wr(tioc_pkg::ADDR_CD_SEL, 16'h0008);
		edge_cap(1'b1, 16'h0707);
		rd(tioc_pkg::ADDR_REG_C, 16'h0C0C);
		wr(tioc_pkg::ADDR_CD_SEL, 16'h0002);
		@(posedge clock_i);
		check({15'h0, ch0_pin_c_oe_o}, 16'h0000);
		wr(tioc_pkg::ADDR_CTRL, 16'h0000);
		@(posedge clock_i);
		check({14'h0, ch0_pin_c_o, ch0_pin_c_oe_o}, 16'h0001);
		$display("test buffer done");
		tally_and_finish();
	end
endmodule
